// ===== logic/tgma_pkg.sv
// Shared constants and stream types for the ten gig MAC stream adapter
// Functional notes
// - Transmit converts 128-bit buffer words to 64-bit beats
// - Transmit converter runs in the MAC clock domain
// - Pop every second cycle, two beats per word, one beat for a last word with an empty upper half
// - Start only when a whole packet is buffered; lengths above 65520 start with no fill check
// - No valid gaps inside a transmitted packet
// - Buffer path 128 bits, MAC path 64 bits
// - Receive MAC stream 64 bits, MAC clock domain
// - Accept every receive beat, never back-pressure
// - Hold whole frame before forwarding any of it
// - Forward good frames, discard bad at frame end
// - Frame length taken from statistics vector
// - Address filter acts only when enabled
// - Compare first 48 bits with station address
// - Broadcast and promiscuous frames always pass
// - Overflow drops whole frames, never partial
// - Pack two 64-bit reads per 128-bit write, one read for an unpaired last beat
package tgma_pkg;
	localparam int unsigned CLK_HZ = 40000000;
	localparam int LEN_W = 14;
	localparam int TX_LEN_W = 16;
	localparam int CNT_W = 13;
	localparam int RX_DEPTH = 4096;
	localparam int LEN_DEPTH = 16;
	localparam logic [47:0] BCAST_ADDR = 48'hffff_ffff_ffff;
	localparam logic [LEN_W-1:0] LEN_RST = 14'h0000;
	localparam logic [3:0] WORD_BYTES_M1 = 4'hf;
	localparam int WORD_SHIFT = 4;

	// Beat of the MAC-facing streams
	typedef struct packed {
		logic [63:0] data;
		logic [7:0] keep;
		logic last;
		logic user;
	} tgma_b64_s;

	// Word of the packet-buffer-facing streams
	typedef struct packed {
		logic [127:0] data;
		logic [15:0] keep;
		logic last;
	} tgma_b128_s;

	typedef enum logic [1:0] {TX_IDLE, TX_POP, TX_HALF} tgma_tx_e;
endpackage : tgma_pkg

// ===== logic/tgma_adapter.sv
// Transmit down converter, receive filter buffer and up converter
module tgma_adapter #(
	parameter int RX_DEPTH = tgma_pkg::RX_DEPTH,
	parameter int LEN_DEPTH = tgma_pkg::LEN_DEPTH
) (
	input wire logic clk_sys_i,
	input wire logic resetn_i,
	input wire logic tx_in_valid_i,
	input wire tgma_pkg::tgma_b128_s tx_in_i,
	input wire logic [tgma_pkg::CNT_W-1:0] tx_rd_count_i,
	input wire logic [tgma_pkg::TX_LEN_W-1:0] tx_head_len_i,
	output logic tx_in_ready_o,
	input wire logic mac_tx_ready_i,
	output logic mac_tx_valid_o,
	output tgma_pkg::tgma_b64_s mac_tx_o,
	input wire logic mac_rx_valid_i,
	input wire tgma_pkg::tgma_b64_s mac_rx_i,
	input wire logic rx_stat_valid_i,
	input wire logic [tgma_pkg::LEN_W-1:0] rx_stat_len_i,
	input wire logic filter_en_i,
	input wire logic promisc_i,
	input wire logic [47:0] station_addr_i,
	output logic rx_out_valid_o,
	output tgma_pkg::tgma_b128_s rx_out_o,
	output logic [tgma_pkg::LEN_W-1:0] rx_out_len_o,
	input wire logic rx_out_ready_i
);
	localparam int AW = $clog2(RX_DEPTH);
	localparam int LW = $clog2(LEN_DEPTH);

	// Transmit side, all in the one MAC clock domain
	tgma_pkg::tgma_tx_e tx_st_r;
	logic [63:0] tx_hi_r;
	logic [7:0] tx_hi_keep_r;
	logic tx_hi_last_r;
	wire [tgma_pkg::TX_LEN_W-1:0] tx_len_up = tx_head_len_i + {12'h000, tgma_pkg::WORD_BYTES_M1};
	// Whole words rounded up in 16 bits; lengths above 65520 wrap to a need of 0, and the top bit of the count is never set
	wire [tgma_pkg::CNT_W-1:0] tx_need =
		tgma_pkg::CNT_W'(tx_len_up[tgma_pkg::TX_LEN_W-1:tgma_pkg::WORD_SHIFT]);
	// Fill count covers the whole head packet up to 65520 bytes, so no gap can appear later
	wire tx_start = (tx_st_r == tgma_pkg::TX_IDLE) && tx_in_valid_i && (tx_head_len_i != 16'h0000)
		&& (tx_rd_count_i >= tx_need) && mac_tx_ready_i;
	wire tx_pop = (tx_st_r == tgma_pkg::TX_POP) && tx_in_valid_i;
	wire tx_short = tx_in_i.last && (tx_in_i.keep[15:8] == 8'h00);

	// Pop, then replay the upper half; ready drops every other cycle
	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			tx_st_r <= tgma_pkg::TX_IDLE;
			tx_in_ready_o <= 1'b0;
			mac_tx_valid_o <= 1'b0;
			mac_tx_o <= '0;
			tx_hi_r <= 64'h0;
			tx_hi_keep_r <= 8'h00;
			tx_hi_last_r <= 1'b0;
		end else begin
			case (tx_st_r)
				tgma_pkg::TX_IDLE: begin
					mac_tx_valid_o <= 1'b0;
					if (tx_start) begin
						tx_st_r <= tgma_pkg::TX_POP;
						tx_in_ready_o <= 1'b1;
					end
				end
				tgma_pkg::TX_POP: begin
					if (tx_pop) begin
						tx_in_ready_o <= 1'b0;
						mac_tx_valid_o <= 1'b1;
						mac_tx_o.data <= tx_in_i.data[63:0];
						mac_tx_o.keep <= tx_in_i.keep[7:0];
						mac_tx_o.last <= tx_short;
						mac_tx_o.user <= 1'b0;
						tx_hi_r <= tx_in_i.data[127:64];
						tx_hi_keep_r <= tx_in_i.keep[15:8];
						tx_hi_last_r <= tx_in_i.last;
						tx_st_r <= tx_short ? tgma_pkg::TX_IDLE : tgma_pkg::TX_HALF;
					end
				end
				tgma_pkg::TX_HALF: begin
					mac_tx_valid_o <= 1'b1;
					mac_tx_o.data <= tx_hi_r;
					mac_tx_o.keep <= tx_hi_keep_r;
					mac_tx_o.last <= tx_hi_last_r;
					tx_in_ready_o <= !tx_hi_last_r;
					tx_st_r <= tx_hi_last_r ? tgma_pkg::TX_IDLE : tgma_pkg::TX_POP;
				end
				default: tx_st_r <= tgma_pkg::TX_IDLE;
			endcase
		end
	end

	// Receive buffer: write pointer may rewind to the commit pointer
	tgma_pkg::tgma_b64_s rx_mem [RX_DEPTH];
	logic [tgma_pkg::LEN_W-1:0] len_mem [LEN_DEPTH];
	logic [AW:0] wr_ptr_r;
	logic [AW:0] commit_ptr_r;
	logic [AW:0] rd_ptr_r;
	logic [LW:0] lwr_r;
	logic [LW:0] lrd_r;
	logic rx_first_r;
	logic rx_drop_r;
	logic [tgma_pkg::LEN_W-1:0] stat_len_r;
	logic have_low_r;
	tgma_pkg::tgma_b64_s low_r;

	// Filter decision on the first beat; the MAC never sees a ready
	wire [AW:0] rx_fill = wr_ptr_r - rd_ptr_r;
	wire rx_full = rx_fill == (AW+1)'(RX_DEPTH);
	wire len_full = (lwr_r - lrd_r) == (LW+1)'(LEN_DEPTH);
	wire addr_hit = (mac_rx_i.data[47:0] == station_addr_i)
		|| (mac_rx_i.data[47:0] == tgma_pkg::BCAST_ADDR) || promisc_i;
	wire addr_ok = !filter_en_i || addr_hit;
	wire drop_eff = rx_first_r ? !addr_ok : rx_drop_r;
	wire rx_space = !rx_full && (!mac_rx_i.last || !len_full);
	wire rx_wr = mac_rx_valid_i && !drop_eff && rx_space;
	wire rx_commit = rx_wr && mac_rx_i.last && mac_rx_i.user;
	wire rx_rewind = mac_rx_valid_i && mac_rx_i.last && !rx_commit;
	wire [tgma_pkg::LEN_W-1:0] frame_len = rx_stat_valid_i ? rx_stat_len_i : stat_len_r;

	// Entry store, no reset on the array
	always_ff @(posedge clk_sys_i) begin
		if (rx_wr) begin
			rx_mem[wr_ptr_r[AW-1:0]] <= mac_rx_i;
		end
		if (rx_commit) begin
			len_mem[lwr_r[LW-1:0]] <= frame_len;
		end
	end

	// Frame bookkeeping; a dropped frame rewinds to the last commit
	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			wr_ptr_r <= '0;
			commit_ptr_r <= '0;
			lwr_r <= '0;
			rx_first_r <= 1'b1;
			rx_drop_r <= 1'b0;
			stat_len_r <= tgma_pkg::LEN_RST;
		end else begin
			if (rx_stat_valid_i) begin
				stat_len_r <= rx_stat_len_i;
			end
			if (rx_rewind) begin
				wr_ptr_r <= commit_ptr_r;
			end else if (rx_wr) begin
				wr_ptr_r <= wr_ptr_r + 1'b1;
			end
			if (rx_commit) begin
				commit_ptr_r <= wr_ptr_r + 1'b1;
				lwr_r <= lwr_r + 1'b1;
			end
			if (mac_rx_valid_i) begin
				rx_first_r <= mac_rx_i.last;
				rx_drop_r <= !mac_rx_i.last && !rx_wr;
			end
		end
	end

	// Read side only sees committed entries
	tgma_pkg::tgma_b64_s rx_ent;
	assign rx_ent = rx_mem[rd_ptr_r[AW-1:0]];
	wire rx_avail = rd_ptr_r != commit_ptr_r;
	wire out_free = !rx_out_valid_o || rx_out_ready_i;
	wire rx_rd = rx_avail && out_free;
	wire rx_emit = rx_rd && (have_low_r || rx_ent.last);
	wire [127:0] pack_data = have_low_r ? {rx_ent.data, low_r.data} : {64'h0, rx_ent.data};
	wire [15:0] pack_keep = have_low_r ? {rx_ent.keep, low_r.keep} : {8'h00, rx_ent.keep};

	// Up converter: two reads make one output word, one read for an unpaired last beat
	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			rd_ptr_r <= '0;
			lrd_r <= '0;
			have_low_r <= 1'b0;
			low_r <= '0;
			rx_out_valid_o <= 1'b0;
			rx_out_o <= '0;
			rx_out_len_o <= tgma_pkg::LEN_RST;
		end else begin
			if (rx_rd) begin
				rd_ptr_r <= rd_ptr_r + 1'b1;
				have_low_r <= !have_low_r && !rx_ent.last;
				low_r <= rx_ent;
			end
			if (rx_emit) begin
				rx_out_valid_o <= 1'b1;
				rx_out_o.data <= pack_data;
				rx_out_o.keep <= pack_keep;
				rx_out_o.last <= rx_ent.last;
				rx_out_len_o <= len_mem[lrd_r[LW-1:0]];
				if (rx_ent.last) begin
					lrd_r <= lrd_r + 1'b1;
				end
			end else if (rx_out_ready_i) begin
				rx_out_valid_o <= 1'b0;
			end
		end
	end

	// Checks beside the logic
	sequence s_tx_pop;
		tx_in_ready_o && tx_in_valid_i;
	endsequence

	sequence s_tx_two_beats;
		mac_tx_valid_o ##1 mac_tx_valid_o;
	endsequence

	property p_tx_pair;
		@(posedge clk_sys_i) disable iff (!resetn_i)
		(s_tx_pop ##0 !tx_short) |=> s_tx_two_beats;
	endproperty

	a_tx_pop_spacing: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
		tx_in_ready_o |=> !tx_in_ready_o) else $error("buffer popped on adjacent cycles");
	a_tx_two_beats: assert property (p_tx_pair) else $error("word not sent as two beats");
	a_tx_no_gap: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
		mac_tx_valid_o && !mac_tx_o.last |=> mac_tx_valid_o) else $error("gap inside packet");
	a_tx_start_gate: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
		$rose(tx_in_ready_o) && $past(tx_st_r == tgma_pkg::TX_IDLE)
		|-> $past(tx_rd_count_i >= tx_need)) else $error("packet started before fully stored");
	a_tx_low_first: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
		s_tx_pop |=> mac_tx_o.data == $past(tx_in_i.data[63:0])) else $error("upper half sent first");
	a_tx_skip_empty: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
		s_tx_pop ##0 tx_short |=> mac_tx_o.last ##1 !mac_tx_valid_o) else $error("empty beat sent");
	a_rx_bad_drop: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
		mac_rx_valid_i && mac_rx_i.last && !mac_rx_i.user |=> $stable(commit_ptr_r))
		else $error("bad frame committed");
	a_rx_filter_drop: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
		mac_rx_valid_i && rx_first_r && filter_en_i && !addr_hit |-> !rx_wr)
		else $error("filtered frame written");
	a_rx_whole_only: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
		rx_out_valid_o && !rx_out_o.last |=> rx_out_valid_o || $past(!rx_out_ready_i) || rx_avail
		|| have_low_r) else $error("partial frame forwarded");
	a_rx_pack_pair: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
		rx_rd && !have_low_r && !rx_ent.last |=> have_low_r && (low_r == $past(rx_ent)))
		else $error("low half not held");
endmodule : tgma_adapter

// ===== verification/tgma_mac_model.sv
// MAC core model: receive frame source and always-ready transmit sink
module tgma_mac_model (
	input wire logic clk_sys_i,
	output logic mac_tx_ready_o,
	output logic mac_rx_valid_o,
	output tgma_pkg::tgma_b64_s mac_rx_o,
	output logic rx_stat_valid_o,
	output logic [tgma_pkg::LEN_W-1:0] rx_stat_len_o
);
	timeunit 1ns;
	timeprecision 100ps;
	// Idle outputs at time zero; the sink takes every beat
	initial begin
		mac_tx_ready_o = 1'b1;
		mac_rx_valid_o = 1'b0;
		mac_rx_o = '0;
		rx_stat_valid_o = 1'b0;
		rx_stat_len_o = '0;
	end
	// Frame of n beats with no gaps, since the core cannot be stalled
	task automatic send(input int n, input logic good, input logic [47:0] da);
		for (int i = 0; i < n; i++) begin
			@(posedge clk_sys_i);
			mac_rx_valid_o <= 1'b1;
			mac_rx_o.data <= (i == 0) ? {16'h0a0b, da} : {56'h5a5a_5a5a_5a5a_5a, 8'(i)};
			mac_rx_o.keep <= 8'hff;
			mac_rx_o.last <= (i == n - 1);
			mac_rx_o.user <= (i == n - 1) && good;
			rx_stat_valid_o <= (i == n - 1);
			rx_stat_len_o <= 14'(n * 8);
		end
		// Released bus shows the inverse so stale data never looks valid
		@(posedge clk_sys_i);
		mac_rx_valid_o <= 1'b0;
		mac_rx_o.data <= ~mac_rx_o.data;
		rx_stat_valid_o <= 1'b0;
	endtask : send
endmodule : tgma_mac_model

// ===== verification/ten_gig_mac_stream_adapter_test.sv
// Self-checking bench for the ten gig MAC stream adapter
module ten_gig_mac_stream_adapter_test;
	timeunit 1ns;
	timeprecision 100ps;
	logic clk_sys_i = 1'b0;
	logic resetn_i = 1'b0;
	logic tx_in_valid = 1'b0;
	tgma_pkg::tgma_b128_s tx_in = '0;
	tgma_pkg::tgma_b128_s w [0:3];
	logic [12:0] tx_rd_count = '0;
	logic [15:0] tx_head_len = '0;
	logic tx_in_ready, mac_tx_ready, mac_tx_valid, mac_rx_valid, stat_valid, rx_out_valid;
	tgma_pkg::tgma_b64_s mac_tx, mac_rx;
	logic [13:0] stat_len, rx_out_len;
	tgma_pkg::tgma_b128_s rx_out;
	logic filter_en = 1'b0;
	logic promisc = 1'b0;
	logic rx_ready = 1'b1;
	int idx = 0;
	int bad_count = 0;
	int check_count = 0;
	localparam logic [47:0] STA = 48'h0012_3456_789a;
	always #12.5 clk_sys_i = ~clk_sys_i;
	// Head-of-buffer model: next word appears after each pop
	always @(posedge clk_sys_i) begin
		if (tx_in_ready) begin
			idx <= idx + 1;
			tx_in <= w[idx + 1];
			tx_in_valid <= (idx < 2);
		end
	end
	tgma_adapter #(.RX_DEPTH(64), .LEN_DEPTH(4)) DUT (.clk_sys_i(clk_sys_i),
		.resetn_i(resetn_i), .tx_in_valid_i(tx_in_valid), .tx_in_i(tx_in),
		.tx_rd_count_i(tx_rd_count), .tx_head_len_i(tx_head_len), .tx_in_ready_o(tx_in_ready),
		.mac_tx_ready_i(mac_tx_ready), .mac_tx_valid_o(mac_tx_valid), .mac_tx_o(mac_tx),
		.mac_rx_valid_i(mac_rx_valid), .mac_rx_i(mac_rx), .rx_stat_valid_i(stat_valid),
		.rx_stat_len_i(stat_len), .filter_en_i(filter_en), .promisc_i(promisc),
		.station_addr_i(STA), .rx_out_valid_o(rx_out_valid), .rx_out_o(rx_out),
		.rx_out_len_o(rx_out_len), .rx_out_ready_i(rx_ready));
	tgma_mac_model mac (.clk_sys_i(clk_sys_i), .mac_tx_ready_o(mac_tx_ready),
		.mac_rx_valid_o(mac_rx_valid), .mac_rx_o(mac_rx), .rx_stat_valid_o(stat_valid),
		.rx_stat_len_o(stat_len));
	task automatic check(input logic [127:0] a, input logic [127:0] e);
		check_count++;
		if (a !== e) begin
			bad_count++;
			$display("unexpected at %0t: got %h expected %h", $time, a, e);
		end
	endtask : check
	task automatic results;
		$display("checks %0d mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask : results
	// 40-byte packet: held back until whole, then five gapless beats
	task automatic tx_test;
		int j;
		for (j = 0; j < 4; j++) begin
			w[j].data = {64'(2 * j + 1), 64'(2 * j)};
			w[j].keep = (j == 2) ? 16'h00ff : 16'hffff;
			w[j].last = (j == 2);
		end
		tx_in <= w[0];
		tx_in_valid <= 1'b1;
		tx_head_len <= 16'h0028;
		tx_rd_count <= 13'h0002;
		repeat (12) @(negedge clk_sys_i);
		check(mac_tx_valid, 1'b0);
		@(posedge clk_sys_i);
		tx_rd_count <= 13'h0003;
		for (j = 0; j < 40 && mac_tx_valid !== 1'b1; j++) @(negedge clk_sys_i);
		if (j == 40) begin
			bad_count++;
			results();
		end
		// Pop strobe high on every second beat only
		for (j = 0; j < 5; j++) begin
			check({mac_tx_valid, tx_in_ready, mac_tx.last, mac_tx.user, mac_tx.keep, mac_tx.data},
				{1'b1, j % 2 == 1, j == 4, 1'b0, 8'hff, 64'(j)});
			@(negedge clk_sys_i);
		end
		check(mac_tx_valid, 1'b0);
		@(posedge clk_sys_i);
		tx_head_len <= '0;
		tx_rd_count <= '0;
	endtask : tx_test
	// Send one frame and count the 128-bit words that come out
	task automatic rx_case(input int n, input logic good, input logic [47:0] da,
		input logic fe, input logic pm, input logic exp);
		int k;
		int t;
		@(posedge clk_sys_i);
		filter_en <= fe;
		promisc <= pm;
		mac.send(n, good, da);
		k = 0;
		for (t = 0; t < 60 && !(exp && k * 2 >= n); t++) begin
			@(negedge clk_sys_i);
			if (rx_out_valid === 1'b1) begin
				if (k == 0) check({rx_out_len, rx_out.data[47:0]}, {14'(n * 8), da});
				if (k == 0) check(rx_out.data[127:64], {56'h5a5a_5a5a_5a5a_5a, 8'h01});
				if (k * 2 + 2 >= n) check({rx_out.last, rx_out.keep},
					{1'b1, (n % 2) ? 16'h00ff : 16'hffff});
				k++;
			end
		end
		check(k, exp ? (n + 1) / 2 : 0);
		if (exp && k * 2 < n) results();
	endtask : rx_case
	// Output word must stand while downstream holds ready low
	task automatic rx_stall;
		int t;
		@(posedge clk_sys_i);
		rx_ready <= 1'b0;
		filter_en <= 1'b0;
		mac.send(2, 1'b1, STA);
		repeat (4) @(negedge clk_sys_i);
		for (t = 0; t < 6; t++) begin
			check({rx_out_valid, rx_out.last, rx_out.data[47:0]}, {1'b1, 1'b1, STA});
			@(negedge clk_sys_i);
		end
		@(posedge clk_sys_i);
		rx_ready <= 1'b1;
		repeat (2) @(negedge clk_sys_i);
		check(rx_out_valid, 1'b0);
	endtask : rx_stall
	initial begin
		repeat (8) @(posedge clk_sys_i);
		resetn_i <= 1'b1;
		repeat (2) @(posedge clk_sys_i);
		tx_test();
		rx_case(3, 1'b1, 48'h0201_0304_0506, 1'b0, 1'b0, 1'b1);
		rx_case(2, 1'b0, 48'h0201_0304_0506, 1'b0, 1'b0, 1'b0);
		rx_case(4, 1'b1, 48'h0a0a_0b0b_0c0c, 1'b1, 1'b0, 1'b0);
		rx_case(4, 1'b1, STA, 1'b1, 1'b0, 1'b1);
		rx_case(5, 1'b1, 48'hffff_ffff_ffff, 1'b1, 1'b0, 1'b1);
		rx_case(2, 1'b1, 48'h0a0a_0b0b_0c0c, 1'b1, 1'b1, 1'b1);
		rx_stall();
		results();
	end
endmodule : ten_gig_mac_stream_adapter_test
